// ---- rtl/pmcl_top.sv ----
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "pmcl_map.svh"
// Overview of operation
// - eee off until software sets enable
// - eee only with mii, txer, bits, 100fdx
// - eee capability/advert defaults follow enable bit
// - isolate ignores mac transmit, keeps management
// - isolate reads zero after power-up
// - resets restore defaults; kept bits survive soft
// - power-down changes no register
// - slow mac clock 16 us, then fast while autoneg enable is set
// - soft reset self-clears, done within 0.5 s
// - carrier on crs or crs_dv, duplex-aware
// - carrier from zeros, dropped on ten ones
// - stream carrier ends at T/R or idles
// - col on tx and rx, off in fdx unless collision test
// - collision test follows transmit enable
// - link status picks 100 or 10 link by speed bit
// - link-ready waits autoneg, else straight up
// - 330 ms settle; data-valid loss drops link at 100 Mb only
// - loopback returns tx data, line tx off
// - loopback col quiet unless collision test
// - far loopback echoes line, isolates mac, rmii
// - irq-function strap taken at reset release
module pmcl_top
	import pmcl_pkg::*;
#(
	parameter int STABLE_CYC = `PMCL_STABLE_CYC
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic hwResetN,
	input wire logic reducedMiiSelectStrap,
	input wire logic irqPinFunctionStrap,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdData,
	input wire logic txEn,
	input wire logic txEr,
	input wire logic [3:0] txData,
	output logic rxDv,
	output logic [3:0] rxData,
	output logic crs,
	output logic crsDv,
	output logic col,
	input wire logic rxBitClk,
	input wire logic rxCodeBit,
	input wire logic lineRxDv,
	input wire logic [3:0] lineRxData,
	output logic lineTxEn,
	output logic [3:0] lineTxData,
	input wire logic dataValid,
	input wire logic anLinkEnable,
	input wire logic link10,
	output logic linkIndicator,
	output logic miiRateFast,
	output logic eeeActive
);
	// ==========================================
	// input synchronisers
	localparam int NSYNC = 19;
	logic [NSYNC-1:0] syncA_reg;
	logic [NSYNC-1:0] syncB_reg;
	wire logic [NSYNC-1:0] rawIn = {hwResetN, reducedMiiSelectStrap, irqPinFunctionStrap,
		rxBitClk, rxCodeBit, dataValid, anLinkEnable, link10, txEn, txEr, txData,
		lineRxDv, lineRxData};

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			syncA_reg <= '0;
			syncB_reg <= '0;
		end else begin
			syncA_reg <= rawIn;
			syncB_reg <= syncA_reg;
		end
	end

	wire logic sHwRstN = syncB_reg[18];
	wire logic sRmii = syncB_reg[17];
	wire logic sIrqSel = syncB_reg[16];
	wire logic sBitClk = syncB_reg[15];
	wire logic sCode = syncB_reg[14];
	wire logic sDataValid = syncB_reg[13];
	wire logic sAnEn = syncB_reg[12];
	wire logic sLink10 = syncB_reg[11];
	wire logic sTxEn = syncB_reg[10];
	wire logic sTxEr = syncB_reg[9];
	wire logic [3:0] sTxData = syncB_reg[8:5];
	wire logic sLineDv = syncB_reg[4];
	wire logic [3:0] sLineData = syncB_reg[3:0];

	// ==========================================
	// hardware reset pin and straps
	logic hwRstPrev_reg;
	logic strapTake_reg;
	logic rmiiStrap_reg;
	logic irqStrap_reg;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			hwRstPrev_reg <= 1'b0;
			strapTake_reg <= 1'b1;
		end else begin
			hwRstPrev_reg <= sHwRstN;
			strapTake_reg <= 1'b0;
		end
	end

	wire logic hwRstHold = !sHwRstN;
	wire logic hwRstRise = sHwRstN && !hwRstPrev_reg;

	// strap sampled after power-on release and on each pin release
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rmiiStrap_reg <= 1'b0;
			irqStrap_reg <= 1'b1;
		end else if (strapTake_reg || hwRstRise) begin
			rmiiStrap_reg <= sRmii;
			irqStrap_reg <= sIrqSel;
		end
	end

	// ==========================================
	// register file
	logic [15:0] ctrl_reg;
	logic [15:0] mode_reg;
	logic advSet_reg;
	logic advWritten_reg;
	logic srstBusy_reg;
	logic [4:0] srstCnt_reg;

	wire logic wrCtrl = regWr && regAddr == `PMCL_OFS_CTRL;
	wire logic wrMode = regWr && regAddr == `PMCL_OFS_MODE;
	wire logic wrEee = regWr && regAddr == `PMCL_OFS_EEE;
	wire logic srstStart = wrCtrl && regWrData[`PMCL_CTRL_SRST];
	wire logic clearRegs = hwRstHold || srstStart;

	// power-down is only a stored bit here; nothing else is touched
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ctrl_reg <= `PMCL_CTRL_RST;
		end else if (clearRegs) begin
			ctrl_reg <= `PMCL_CTRL_RST;
		end else if (wrCtrl) begin
			ctrl_reg <= regWrData;
		end
	end

	// eee enable is kept on soft reset, far loopback is not
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			mode_reg <= `PMCL_MODE_RST;
		end else if (hwRstHold) begin
			mode_reg <= `PMCL_MODE_RST;
		end else if (srstStart) begin
			mode_reg[`PMCL_MODE_FARLB] <= 1'b0;
		end else if (wrMode) begin
			mode_reg <= regWrData;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			advSet_reg <= 1'b0;
			advWritten_reg <= 1'b0;
		end else if (clearRegs) begin
			advSet_reg <= 1'b0;
			advWritten_reg <= 1'b0;
		end else if (wrEee) begin
			advSet_reg <= regWrData[`PMCL_EEE_ADV];
			advWritten_reg <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			srstBusy_reg <= 1'b0;
			srstCnt_reg <= 5'h00;
		end else if (srstStart) begin
			srstBusy_reg <= 1'b1;
			srstCnt_reg <= 5'(`PMCL_SRST_CYC - 1);
		end else if (srstBusy_reg) begin
			srstCnt_reg <= srstCnt_reg - 5'h01;
			srstBusy_reg <= srstCnt_reg != 5'h00;
		end
	end

	wire logic loopBit = ctrl_reg[`PMCL_CTRL_LOOP];
	wire logic isoBit = ctrl_reg[`PMCL_CTRL_ISO];
	wire logic colTest = ctrl_reg[`PMCL_CTRL_COLT];
	wire logic fdxBit = ctrl_reg[`PMCL_CTRL_FDX];
	wire logic anEnBit = ctrl_reg[`PMCL_CTRL_ANEN];
	wire logic spd100 = ctrl_reg[`PMCL_CTRL_SPD100];
	wire logic rptBit = ctrl_reg[`PMCL_CTRL_RPT];
	wire logic eeeEnable = mode_reg[`PMCL_MODE_EEEEN];
	wire logic farLoop = mode_reg[`PMCL_MODE_FARLB] && rmiiStrap_reg;
	wire logic eeeCap = eeeEnable;
	wire logic eeeAdv = advWritten_reg ? advSet_reg : eeeEnable;

	// ==========================================
	// mac interface rate after reset
	logic [9:0] slowCnt_reg;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			slowCnt_reg <= 10'(`PMCL_SLOW_CYC);
		end else if (hwRstHold || srstStart) begin
			slowCnt_reg <= 10'(`PMCL_SLOW_CYC);
		end else if (slowCnt_reg != 10'h000) begin
			slowCnt_reg <= slowCnt_reg - 10'h001;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			miiRateFast <= 1'b0;
		end else begin
			miiRateFast <= slowCnt_reg == 10'h000 && anEnBit;
		end
	end

	// ==========================================
	// carrier sense on the code-bit stream
	function automatic logic zerosApart(input logic [9:0] w);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 8; i++) begin
			for (int j = i + 2; j < 10; j++) begin
				if (!w[i] && !w[j]) begin
					hit = 1'b1;
				end
			end
		end
		return hit;
	endfunction

	logic bitClkPrev_reg;
	logic [9:0] win_reg;
	logic [2:0] symCnt_reg;
	logic [3:0] onesCnt_reg;
	pmcl_carrier_t cs_reg;
	pmcl_carrier_t cs_next;
	logic carrier_reg;
	logic carrier_next;

	wire logic bitTick = sBitClk && !bitClkPrev_reg;
	wire logic [9:0] winNow = {win_reg[8:0], sCode};
	wire logic symEnd = symCnt_reg == 3'h4;
	wire logic [4:0] symNow = winNow[4:0];
	// old stream bits must not raise a false carrier after the end delimiter
	wire logic streamDone = (cs_reg == CS_AFTER_T || cs_reg == CS_AFTER_I) && cs_next == CS_IDLE;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			bitClkPrev_reg <= 1'b0;
			win_reg <= 10'h3ff;
			onesCnt_reg <= 4'h0;
		end else begin
			bitClkPrev_reg <= sBitClk;
			if (bitTick) begin
				win_reg <= streamDone ? 10'h3ff : winNow;
				onesCnt_reg <= !sCode ? 4'h0 : (onesCnt_reg == 4'ha) ? 4'ha : onesCnt_reg + 4'h1;
			end
		end
	end

	always_comb begin
		cs_next = cs_reg;
		carrier_next = carrier_reg;
		case (cs_reg)
			CS_IDLE: begin
				if (zerosApart(winNow)) begin
					cs_next = CS_FALSE;
					carrier_next = 1'b1;
				end
			end
			CS_FALSE: begin
				if (winNow == {`PMCL_SYM_J, `PMCL_SYM_K}) begin
					cs_next = CS_STREAM;
				end else if (sCode && onesCnt_reg >= 4'h9) begin
					cs_next = CS_IDLE;
					carrier_next = 1'b0;
				end
			end
			CS_STREAM: begin
				if (symEnd && symNow == `PMCL_SYM_T) begin
					cs_next = CS_AFTER_T;
					carrier_next = 1'b0;
				end else if (symEnd && symNow == `PMCL_SYM_I) begin
					cs_next = CS_AFTER_I;
					carrier_next = 1'b0;
				end
			end
			CS_AFTER_T: begin
				if (symEnd) begin
					cs_next = symNow == `PMCL_SYM_R ? CS_IDLE : CS_STREAM;
					carrier_next = symNow != `PMCL_SYM_R;
				end
			end
			CS_AFTER_I: begin
				if (symEnd) begin
					cs_next = symNow == `PMCL_SYM_I ? CS_IDLE : CS_STREAM;
					carrier_next = symNow != `PMCL_SYM_I;
				end
			end
			default: begin
				cs_next = CS_IDLE;
				carrier_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cs_reg <= CS_IDLE;
			carrier_reg <= 1'b0;
			symCnt_reg <= 3'h0;
		end else if (hwRstHold || srstStart) begin
			cs_reg <= CS_IDLE;
			carrier_reg <= 1'b0;
			symCnt_reg <= 3'h0;
		end else if (bitTick) begin
			cs_reg <= cs_next;
			carrier_reg <= carrier_next;
			if (cs_reg == CS_FALSE && cs_next == CS_STREAM) begin
				symCnt_reg <= 3'h0;
			end else begin
				symCnt_reg <= symEnd ? 3'h0 : symCnt_reg + 3'h1;
			end
		end
	end

	// ==========================================
	// mac-facing data path, loopbacks, collision
	wire logic macTxEn = sTxEn && !isoBit && !farLoop;
	wire logic rxOnly = fdxBit || rptBit;
	wire logic realCol = macTxEn && carrier_reg && !fdxBit && !loopBit;
	wire logic testCol = colTest && macTxEn;
	wire logic crsNow = carrier_reg || (!rxOnly && macTxEn);
	wire logic macQuiet = isoBit || farLoop;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rxDv <= 1'b0;
			rxData <= 4'h0;
			crs <= 1'b0;
			crsDv <= 1'b0;
			col <= 1'b0;
		end else begin
			if (macQuiet) begin
				rxDv <= 1'b0;
				rxData <= 4'h0;
			end else if (loopBit) begin
				rxDv <= macTxEn;
				rxData <= sTxData;
			end else begin
				rxDv <= sLineDv;
				rxData <= sLineData;
			end
			crs <= !macQuiet && !rmiiStrap_reg && crsNow;
			crsDv <= !macQuiet && rmiiStrap_reg && crsNow;
			col <= !macQuiet && (realCol || testCol);
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			lineTxEn <= 1'b0;
			lineTxData <= 4'h0;
		end else if (farLoop) begin
			lineTxEn <= sLineDv;
			lineTxData <= sLineData;
		end else if (loopBit || !macTxEn) begin
			lineTxEn <= 1'b0;
			lineTxData <= 4'h0;
		end else begin
			lineTxEn <= 1'b1;
			lineTxData <= sTxEr ? 4'h0 : sTxData;
		end
	end

	// ==========================================
	// link monitor
	pmcl_link_t lm_reg;
	logic [31:0] lmCnt_reg;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			lm_reg <= LM_DOWN;
			lmCnt_reg <= 32'h0;
		end else if (hwRstHold || srstStart || !sDataValid) begin
			lm_reg <= LM_DOWN;
			lmCnt_reg <= 32'h0;
		end else begin
			case (lm_reg)
				LM_DOWN: begin
					lm_reg <= LM_WAIT;
					lmCnt_reg <= 32'h1;
				end
				LM_WAIT: begin
					if (lmCnt_reg >= 32'(STABLE_CYC)) begin
						lm_reg <= anEnBit ? LM_READY : LM_UP;
					end else begin
						lmCnt_reg <= lmCnt_reg + 32'h1;
					end
				end
				LM_READY: begin
					if (sAnEn || !anEnBit) begin
						lm_reg <= LM_UP;
					end
				end
				LM_UP: begin
					lm_reg <= LM_UP;
				end
				default: begin
					lm_reg <= LM_DOWN;
				end
			endcase
		end
	end

	wire logic linkNow = spd100 ? lm_reg == LM_UP : sLink10;
	wire logic eeeNow = !rmiiStrap_reg && !irqStrap_reg && eeeEnable && eeeAdv
		&& spd100 && fdxBit && linkNow;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			linkIndicator <= 1'b0;
			eeeActive <= 1'b0;
		end else begin
			linkIndicator <= linkNow;
			eeeActive <= eeeNow;
		end
	end

	// ==========================================
	// register read port, data one cycle after the strobe
	logic [15:0] rdMux;

	always_comb begin
		rdMux = 16'h0000;
		case (regAddr)
			`PMCL_OFS_CTRL: begin
				rdMux = ctrl_reg;
				rdMux[`PMCL_CTRL_SRST] = srstBusy_reg;
			end
			`PMCL_OFS_MODE: rdMux = mode_reg;
			`PMCL_OFS_EEE: begin
				rdMux[`PMCL_EEE_CAP] = eeeCap;
				rdMux[`PMCL_EEE_ADV] = eeeAdv;
			end
			`PMCL_OFS_STAT: begin
				rdMux[`PMCL_STAT_LINK] = linkIndicator;
				rdMux[`PMCL_STAT_EEEACT] = eeeActive;
				rdMux[`PMCL_STAT_CRS] = carrier_reg;
				rdMux[`PMCL_STAT_COL] = col;
				rdMux[`PMCL_STAT_FAST] = miiRateFast;
				rdMux[`PMCL_STAT_RMII] = rmiiStrap_reg;
				rdMux[`PMCL_STAT_IRQSEL] = irqStrap_reg;
				rdMux[`PMCL_STAT_LSTATE +: 2] = lm_reg;
			end
			default: rdMux = 16'h0000;
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			regRdData <= 16'h0000;
		end else begin
			regRdData <= regRd ? rdMux : 16'h0000;
		end
	end
endmodule

// ---- rtl/pmcl_map.svh ----
`ifndef PMCL_MAP_SVH
`define PMCL_MAP_SVH
// ==========================================
// register offsets (word index on the port)
`define PMCL_OFS_CTRL 4'h0
`define PMCL_OFS_MODE 4'h1
`define PMCL_OFS_EEE 4'h2
`define PMCL_OFS_STAT 4'h3
// ==========================================
// control register fields
`define PMCL_CTRL_LOOP 0
`define PMCL_CTRL_ISO 1
`define PMCL_CTRL_COLT 2
`define PMCL_CTRL_FDX 3
`define PMCL_CTRL_ANEN 4
`define PMCL_CTRL_SPD100 5
`define PMCL_CTRL_PDN 6
`define PMCL_CTRL_RPT 7
`define PMCL_CTRL_SRST 15
`define PMCL_CTRL_RST 16'h0030
// ==========================================
// mode, eee and status fields
`define PMCL_MODE_FARLB 0
`define PMCL_MODE_EEEEN 1
`define PMCL_MODE_RST 16'h0000
`define PMCL_EEE_CAP 0
`define PMCL_EEE_ADV 1
`define PMCL_STAT_LINK 0
`define PMCL_STAT_EEEACT 1
`define PMCL_STAT_CRS 2
`define PMCL_STAT_COL 3
`define PMCL_STAT_FAST 4
`define PMCL_STAT_RMII 5
`define PMCL_STAT_IRQSEL 6
`define PMCL_STAT_LSTATE 8
// ==========================================
// code groups, first received bit is the msb
`define PMCL_SYM_J 5'h18
`define PMCL_SYM_K 5'h11
`define PMCL_SYM_T 5'h0d
`define PMCL_SYM_R 5'h07
`define PMCL_SYM_I 5'h1f
// ==========================================
// timing
`define PMCL_CLK_HZ 40000000
`define PMCL_SLOW_US 16
`define PMCL_SLOW_CYC ((`PMCL_SLOW_US * `PMCL_CLK_HZ + 999999) / 1000000)
`define PMCL_STABLE_MS 330
`define PMCL_STABLE_CYC ((`PMCL_STABLE_MS * (`PMCL_CLK_HZ / 1000)))
`define PMCL_SRST_MAX_MS 500
`define PMCL_SRST_CYC 16
`endif

// ---- rtl/pmcl_pkg.sv ----
package pmcl_pkg;
	typedef enum logic [2:0] {
		CS_IDLE, CS_FALSE, CS_STREAM, CS_AFTER_T, CS_AFTER_I
	} pmcl_carrier_t;
	typedef enum logic [1:0] {
		LM_DOWN, LM_WAIT, LM_READY, LM_UP
	} pmcl_link_t;
endpackage

// ---- sim/pmcl_mac_model.sv ----
`timescale 1ns/10ps
// ========================================
// mac transmit side: one frame of len nibbles, pattern index ^ a
module pmcl_mac_model (
	input wire logic sys_clk,
	input wire logic go,
	input wire logic [7:0] len,
	output logic txEn = 1'b0,
	output logic txEr = 1'b0,
	output logic [3:0] txData = 4'h0,
	output logic busy = 1'b0
);
	logic [7:0] cnt = 8'h00;
	always @(posedge sys_clk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			cnt <= 8'h00;
		end else if (busy && cnt < len) begin
			txEn <= 1'b1;
			txData <= cnt[3:0] ^ 4'ha;
			cnt <= cnt + 8'h01;
		end else begin
			busy <= 1'b0;
			txEn <= 1'b0;
			// idle nibbles toggle so stale data never looks valid
			txData <= ~txData;
		end
	end
endmodule

// ---- sim/pmcl_top_monitor.sv ----
`timescale 1ns/10ps
`include "pmcl_map.svh"
// ========================================
// port checker
module pmcl_top_monitor #(
	parameter int STABLE_CYC = 20
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic hwResetN,
	input wire logic reducedMiiSelectStrap,
	input wire logic irqPinFunctionStrap,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [15:0] regRdData,
	input wire logic txEn,
	input wire logic crs,
	input wire logic crsDv,
	input wire logic col,
	input wire logic rxBitClk,
	input wire logic rxCodeBit,
	input wire logic dataValid,
	input wire logic link10,
	input wire logic linkIndicator,
	input wire logic miiRateFast,
	input wire logic eeeActive
);
	int rateCnt, dvCnt, ones, txLow;
	logic [3:0] l10Sh;
	logic [2:0] bcSh;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// cycles since the last reset of any kind
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			rateCnt <= 0;
		else if (!hwResetN || (regWr && regAddr == 4'h0 && regWrData[15]))
			rateCnt <= 0;
		else if (rateCnt < 1000)
			rateCnt <= rateCnt + 1;
	end
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			dvCnt <= 0;
		else if (!dataValid)
			dvCnt <= 0;
		else if (dvCnt < STABLE_CYC + 8)
			dvCnt <= dvCnt + 1;
	end
	// run of received ones, quiet transmit time, link10 history
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ones <= 0;
			txLow <= 0;
			l10Sh <= 4'h0;
			bcSh <= 3'h0;
		end else begin
			bcSh <= {bcSh[1:0], rxBitClk};
			l10Sh <= {l10Sh[2:0], link10};
			txLow <= txEn ? 0 : (txLow < 100 ? txLow + 1 : txLow);
			if (bcSh[1] && !bcSh[2])
				ones <= rxCodeBit ? (ones < 100 ? ones + 1 : ones) : 0;
		end
	end
	chk_eee_straps: assert property (eeeActive |-> !reducedMiiSelectStrap && !irqPinFunctionStrap)
		else $error("eee active with wrong straps");
	chk_rate_slow: assert property ($rose(miiRateFast) |-> rateCnt >= `PMCL_SLOW_CYC)
		else $error("mac rate fast too early");
	chk_link_settle: assert property ($rose(linkIndicator) |-> (|l10Sh) || dvCnt >= STABLE_CYC)
		else $error("link up before settle time");
	chk_link_drop: assert property ((!dataValid && !link10) [*5] |=> !linkIndicator)
		else $error("link kept without valid data");
	chk_carrier_ones: assert property (ones >= 15 && txLow > 20 |-> !crs && !crsDv)
		else $error("carrier kept over idle line");
	chk_crs_mii: assert property (crs |-> !reducedMiiSelectStrap)
		else $error("crs active in rmii mode");
	chk_crsdv_rmii: assert property (crsDv |-> reducedMiiSelectStrap)
		else $error("crsDv active in mii mode");
	chk_col_release: assert property (!txEn [*4] |=> !col)
		else $error("col held without transmit");
	chk_rd_quiet: assert property (!$past(regRd) |-> regRdData == 16'h0000)
		else $error("read data outside answer cycle");
	cover property ($rose(linkIndicator));
	cover property (crs);
	cover property (col);
endmodule
bind pmcl_top pmcl_top_monitor #(.STABLE_CYC(STABLE_CYC)) u_pmcl_top_monitor (.sys_clk, .reset,
	.hwResetN, .reducedMiiSelectStrap, .irqPinFunctionStrap, .regAddr, .regWrData, .regWr,
	.regRd, .regRdData, .txEn, .crs, .crsDv, .col, .rxBitClk, .rxCodeBit, .dataValid,
	.link10, .linkIndicator, .miiRateFast, .eeeActive);

// ---- sim/pmcl_top_bench.sv ----
`timescale 1ns/10ps
`include "pmcl_map.svh"
module pmcl_top_bench
	import pmcl_pkg::*;
;
	logic sys_clk = 1'b0, reset = 1'b1, hwResetN = 1'b0, regWr = 1'b0, regRd = 1'b0, go = 1'b0;
	logic reducedMiiSelectStrap = 1'b0, irqPinFunctionStrap = 1'b0, lineRxDv = 1'b0;
	logic rxBitClk = 1'b0, rxCodeBit = 1'b1, dataValid = 1'b0, anLinkEnable = 1'b0, link10 = 1'b0;
	logic [3:0] regAddr = 4'h0, lineRxData = 4'h0;
	logic [15:0] regWrData = 16'h0000;
	logic [7:0] len = 8'h08;
	logic txEn, txEr, busy, rxDv, crs, crsDv, col, lineTxEn, linkIndicator, miiRateFast, eeeActive;
	logic [3:0] txData, rxData, lineTxData;
	logic [15:0] regRdData, d;
	logic [31:0] seed = 32'h1932b977;
	int num_errors = 0;
	int cmp_count = 0;
	always #12.5 sys_clk = ~sys_clk;
	pmcl_top #(.STABLE_CYC(20)) u_pmcl_top (.sys_clk, .reset, .hwResetN, .reducedMiiSelectStrap,
		.irqPinFunctionStrap, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .txEn, .txEr,
		.txData, .rxDv, .rxData, .crs, .crsDv, .col, .rxBitClk, .rxCodeBit, .lineRxDv,
		.lineRxData, .lineTxEn, .lineTxData, .dataValid, .anLinkEnable, .link10,
		.linkIndicator, .miiRateFast, .eeeActive);
	pmcl_mac_model u_pmcl_mac_model (.sys_clk, .go, .len, .txEn, .txEr, .txData, .busy);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] eeeExp(input logic en, input logic adv);
		return {14'h0000, adv, en};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= v;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [15:0] e);
		rd(a);
		chk(d, e);
	endtask
	// one code group on the line, first bit first, 200 ns bit clock
	task automatic sym(input logic [4:0] s);
		for (int i = 4; i >= 0; i--) begin
			rxCodeBit <= s[i];
			rxBitClk <= 1'b0;
			repeat (4) @(posedge sys_clk);
			rxBitClk <= 1'b1;
			repeat (4) @(posedge sys_clk);
		end
		#1;
	endtask
	task automatic frame();
		seed = lfsr(seed);
		@(posedge sys_clk);
		len <= 8'h08 + seed[3:0];
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
	endtask
	task automatic frameEnd();
		for (int i = 0; i < 40 && busy === 1'b1; i++) cyc(1);
		cyc(8);
	endtask
	task automatic finish_test();
		$display("errors %0d, compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#400000;
		num_errors++;
		finish_test();
	end
	initial begin
		cyc(2);
		reset <= 1'b0;
		hwResetN <= 1'b1;
		cyc(600);
		chk(miiRateFast, 1'b0);
		cyc(60);
		chk(miiRateFast, 1'b1);
		rchk(`PMCL_OFS_CTRL, `PMCL_CTRL_RST);
		rchk(`PMCL_OFS_MODE, `PMCL_MODE_RST);
		rchk(`PMCL_OFS_EEE, eeeExp(1'b0, 1'b0));
		seed = lfsr(seed);
		wr({1'b1, seed[2:0]}, seed[15:0]);
		rchk({1'b1, seed[5:3]}, 16'h0000);
		rd(`PMCL_OFS_STAT);
		chk(d[6:5], 2'b00);
		wr(`PMCL_OFS_MODE, 16'h0002);
		rchk(`PMCL_OFS_EEE, eeeExp(1'b1, 1'b1));
		wr(`PMCL_OFS_EEE, 16'h0000);
		rchk(`PMCL_OFS_EEE, eeeExp(1'b1, 1'b0));
		wr(`PMCL_OFS_CTRL, 16'h0070);
		wr(`PMCL_OFS_CTRL, 16'h0030);
		rchk(`PMCL_OFS_MODE, 16'h0002);
		rchk(`PMCL_OFS_EEE, eeeExp(1'b1, 1'b0));
		wr(`PMCL_OFS_MODE, 16'h0003);
		wr(`PMCL_OFS_CTRL, 16'h8032);
		rd(`PMCL_OFS_CTRL);
		chk(d[15], 1'b1);
		cyc(20);
		rchk(`PMCL_OFS_CTRL, `PMCL_CTRL_RST);
		rchk(`PMCL_OFS_MODE, 16'h0002);
		sym(`PMCL_SYM_I);
		sym(5'h0a);
		sym(`PMCL_SYM_I);
		chk(crs, 1'b1);
		sym(`PMCL_SYM_I);
		sym(`PMCL_SYM_I);
		chk(crs, 1'b0);
		sym(`PMCL_SYM_J);
		sym(`PMCL_SYM_K);
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			sym({2'b10, seed[2:0]});
		end
		chk(crs, 1'b1);
		chk(crsDv, 1'b0);
		sym(`PMCL_SYM_T);
		sym(5'h16);
		sym(5'h14);
		chk(crs, 1'b1);
		sym(`PMCL_SYM_T);
		sym(`PMCL_SYM_R);
		sym(`PMCL_SYM_I);
		chk(crs, 1'b0);
		rxCodeBit <= 1'b0;
		rxBitClk <= 1'b0;
		dataValid <= 1'b1;
		cyc(8);
		rd(`PMCL_OFS_STAT);
		chk(d[9:8], LM_WAIT);
		cyc(20);
		rd(`PMCL_OFS_STAT);
		chk(d[9:8], LM_READY);
		chk(linkIndicator, 1'b0);
		anLinkEnable <= 1'b1;
		cyc(6);
		chk(linkIndicator, 1'b1);
		wr(`PMCL_OFS_EEE, 16'h0002);
		wr(`PMCL_OFS_CTRL, 16'h0038);
		cyc(4);
		chk(eeeActive, 1'b1);
		frame();
		cyc(8);
		chk(crs, 1'b0);
		chk(col, 1'b0);
		frameEnd();
		wr(`PMCL_OFS_CTRL, 16'h0030);
		cyc(4);
		chk(eeeActive, 1'b0);
		dataValid <= 1'b0;
		cyc(5);
		chk(linkIndicator, 1'b0);
		anLinkEnable <= 1'b0;
		wr(`PMCL_OFS_CTRL, 16'h0020);
		dataValid <= 1'b1;
		cyc(30);
		chk(linkIndicator, 1'b1);
		wr(`PMCL_OFS_CTRL, 16'h0000);
		dataValid <= 1'b0;
		link10 <= 1'b1;
		cyc(6);
		chk(linkIndicator, 1'b1);
		link10 <= 1'b0;
		wr(`PMCL_OFS_CTRL, 16'h0024);
		frame();
		cyc(8);
		chk(col, 1'b1);
		chk(crs, 1'b1);
		chk(lineTxEn, 1'b1);
		frameEnd();
		chk(col, 1'b0);
		wr(`PMCL_OFS_CTRL, 16'h0021);
		frame();
		for (int i = 0; i < 12 && rxDv !== 1'b1; i++) cyc(1);
		chk(rxData, 4'ha);
		chk(lineTxEn, 1'b0);
		chk(col, 1'b0);
		frameEnd();
		wr(`PMCL_OFS_CTRL, 16'h0025);
		frame();
		cyc(8);
		chk(col, 1'b1);
		frameEnd();
		wr(`PMCL_OFS_CTRL, 16'h0022);
		frame();
		cyc(8);
		chk(lineTxEn, 1'b0);
		chk(rxDv, 1'b0);
		rchk(`PMCL_OFS_CTRL, 16'h0022);
		frameEnd();
		hwResetN <= 1'b0;
		cyc(10);
		irqPinFunctionStrap <= 1'b1;
		reducedMiiSelectStrap <= 1'b1;
		cyc(5);
		hwResetN <= 1'b1;
		cyc(4);
		rd(`PMCL_OFS_STAT);
		chk(d[6:5], 2'b11);
		rchk(`PMCL_OFS_MODE, `PMCL_MODE_RST);
		wr(`PMCL_OFS_MODE, 16'h0001);
		seed = lfsr(seed);
		lineRxData <= seed[3:0];
		lineRxDv <= 1'b1;
		cyc(6);
		chk(lineTxEn, 1'b1);
		chk(lineTxData, seed[3:0]);
		chk(rxDv, 1'b0);
		lineRxDv <= 1'b0;
		cyc(4);
		wr(`PMCL_OFS_MODE, 16'h0000);
		frame();
		cyc(8);
		chk(crsDv, 1'b1);
		chk(crs, 1'b0);
		frameEnd();
		finish_test();
	end
endmodule
